// *** design/irs_params.svh ***
// constants of the interrupt request sampling block
`ifndef IRS_PARAMS_SVH
`define IRS_PARAMS_SVH
// =====================================================
// timing
`define IRS_E_DIV        4
`define IRS_SEQ_FIRST    4'h1
`define IRS_SEQ_TENTH    4'hA
`define IRS_SEQ_LAST     4'hC
// =====================================================
// operating modes that route the strobe request
`define IRS_MODE_A       3'h4
`define IRS_MODE_B       3'h7
// =====================================================
// register offsets
`define IRS_CTRL_ADDR    2'h0
`define IRS_STAT_ADDR    2'h1
`define IRS_FLAG_ADDR    2'h2
// =====================================================
// field positions and reset values
`define IRS_CTRL_STRB_EN 0
`define IRS_CTRL_CAPT_EN 1
`define IRS_FLAG_STRB    0
`define IRS_FLAG_CAPT    1
`define IRS_CTRL_RESET   2'h0
`define IRS_LINES_IDLE   3'h7
`endif

// *** design/irs_pkg.sv ***
// types of the interrupt request sampling block
package irs_pkg;
    typedef enum logic [1:0] {
        IRS_SRC_NONE = 2'h0,
        IRS_SRC_NMI  = 2'h1,
        IRS_SRC_EXT  = 2'h2,
        IRS_SRC_PER  = 2'h3
    } irs_src_t;
    typedef struct packed {
        logic nmi;
        logic ext;
        logic per;
    } irs_pend_t;
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] sync3;
        logic [2:0] filt;
        logic [7:0] e_cnt;
        irs_pend_t  samp;
        logic       nmi_prev;
        logic       strb_prev;
        irs_pend_t  pend;
        irs_src_t   select;
        logic       ibit;
        logic       mask_bit_buffer;
        logic       seq_active;
        logic       seq_swi;
        logic [3:0] seq_cnt;
        logic [1:0] ctrl;
        logic       strobe_flag;
        logic       capture_flag;
        logic       strobe_req_n;
        logic       periph_req_n;
        logic [7:0] rd_data;
    } irs_state_t;
endpackage

// *** design/irs_request_sampling.sv ***
// interrupt request sampling, pending latches and mask bit
`timescale 1ns/10ps
`include "irs_params.svh"
// =====================================================
// Summary of operation
// - sample all three request lines at every enable clock falling edge
// - non-maskable line sets its latch only on a high-to-low transition
// - three separate pending latches; the external one is set by the external or the strobe request
// - non-maskable latch cleared at reset and in the tenth cycle of a sequence not started by the software interrupt instruction, not by software
// - maskable latches cleared at reset and held clear while mask set
// - simultaneous set and clear leaves a latch cleared
// - every sequence sets the mask in its tenth cycle
// - external maskable request wins over internal peripheral request
// - mask inhibits maskable requests only, never the non-maskable one
// - mask set by reset, sequences, instructions; cleared only by instructions
// - strobe is edge sensitive; capture and the other maskables are levels
// - timer and serial unit request on the internal peripheral line
// - strobe request low only in mode 4 or 7 with flag and enable
// - request is flag and enable; flag behaves alike whatever the enable
// - request level held through transparent phase and frozen at fall
// - clearing the mask acts one enable cycle late, setting at once
module irs_request_sampling
    import irs_pkg::*;
#(
    parameter int E_DIV = `IRS_E_DIV
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       nonmaskable_request_n_i,
    input  wire logic       external_maskable_request_n_i,
    input  wire logic       port_strobe_input_n_i,
    input  wire logic [2:0] mode_i,
    input  wire logic       capture_event_i,
    input  wire logic       serial_flag_i,
    input  wire logic       serial_enable_i,
    input  wire logic       seq_start_i,
    input  wire logic       software_interrupt_instr_i,
    input  wire logic       mask_set_i,
    input  wire logic       mask_clear_i,
    input  wire logic [1:0] addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rd_data_o,
    output irs_pend_t       pending_o,
    output irs_src_t        service_select_o,
    output logic            mask_bit_o,
    output logic            strobe_interrupt_request_n_o,
    output logic            internal_peripheral_request_n_o,
    output logic            e_fall_o
);
    // =====================================================
    // state
    irs_state_t st;
    irs_state_t next_st;
    logic       e_fall;
    logic       nmi_edge;
    logic       tenth;

    assign e_fall   = (st.e_cnt == 8'(E_DIV - 1));
    assign nmi_edge = e_fall && st.nmi_prev && !st.samp.nmi;
    assign tenth    = e_fall && st.seq_active && (st.seq_cnt == `IRS_SEQ_TENTH);

    // =====================================================
    // next state
    always_comb begin
        logic [2:0] agree;
        logic       strb_edge;
        logic       strb_clr;
        logic       capt_clr;
        logic       ctrl_wr;
        agree     = ~(st.sync2 ^ st.sync3);
        strb_edge = st.strb_prev && !st.filt[2];
        ctrl_wr   = wr_i && (addr_i == `IRS_CTRL_ADDR);
        strb_clr  = wr_i && (addr_i == `IRS_FLAG_ADDR) && wr_data_i[`IRS_FLAG_STRB];
        capt_clr  = wr_i && (addr_i == `IRS_FLAG_ADDR) && wr_data_i[`IRS_FLAG_CAPT];
        next_st   = st;
        // pin synchronisers and agreement filter
        next_st.sync1     = {port_strobe_input_n_i, external_maskable_request_n_i, nonmaskable_request_n_i};
        next_st.sync2     = st.sync1;
        next_st.sync3     = st.sync2;
        next_st.filt      = (agree & st.sync3) | (~agree & st.filt);
        next_st.strb_prev = st.filt[2];
        // enable clock divider
        next_st.e_cnt = e_fall ? 8'h00 : st.e_cnt + 8'h01;
        // peripheral flags, set wins over clear
        next_st.strobe_flag  = strb_edge || (st.strobe_flag && !strb_clr);
        next_st.capture_flag = capture_event_i || (st.capture_flag && !capt_clr);
        if (ctrl_wr) begin
            next_st.ctrl = wr_data_i[1:0];
        end
        // request lines formed from flag and enable
        next_st.strobe_req_n = !(((mode_i == `IRS_MODE_A) || (mode_i == `IRS_MODE_B))
                               && st.strobe_flag && st.ctrl[`IRS_CTRL_STRB_EN]);
        next_st.periph_req_n = !((st.capture_flag && st.ctrl[`IRS_CTRL_CAPT_EN])
                               || (serial_flag_i && serial_enable_i));
        // sampling latch frozen at the enable falling edge
        if (e_fall) begin
            next_st.samp.nmi  = st.filt[0];
            next_st.samp.ext  = st.filt[1] && st.strobe_req_n;
            next_st.samp.per  = st.periph_req_n;
            next_st.nmi_prev  = st.samp.nmi;
        end
        // interrupt sequence cycle counter
        if (seq_start_i && !st.seq_active) begin
            next_st.seq_active = 1'b1;
            next_st.seq_swi    = software_interrupt_instr_i;
            next_st.seq_cnt    = `IRS_SEQ_FIRST;
        end else if (e_fall && st.seq_active) begin
            next_st.seq_cnt    = st.seq_cnt + 4'h1;
            next_st.seq_active = (st.seq_cnt != `IRS_SEQ_LAST);
        end
        // mask bit and its buffer
        if (mask_set_i || tenth) begin
            next_st.mask_bit_buffer = 1'b1;
            next_st.ibit            = 1'b1;
        end else begin
            if (mask_clear_i) begin
                next_st.mask_bit_buffer = 1'b0;
            end
            if (e_fall && !st.mask_bit_buffer) begin
                next_st.ibit = 1'b0;
            end
        end
        // pending latches, clear wins over set
        if (tenth && !st.seq_swi) begin
            next_st.pend.nmi = 1'b0;
        end else if (nmi_edge) begin
            next_st.pend.nmi = 1'b1;
        end
        if (next_st.ibit) begin
            next_st.pend.ext = 1'b0;
            next_st.pend.per = 1'b0;
        end else if (e_fall) begin
            next_st.pend.ext = st.pend.ext || !st.samp.ext;
            next_st.pend.per = st.pend.per || !st.samp.per;
        end
        // priority towards the sequencer
        if (next_st.pend.nmi) begin
            next_st.select = IRS_SRC_NMI;
        end else if (next_st.pend.ext) begin
            next_st.select = IRS_SRC_EXT;
        end else if (next_st.pend.per) begin
            next_st.select = IRS_SRC_PER;
        end else begin
            next_st.select = IRS_SRC_NONE;
        end
        // register read, one cycle later
        next_st.rd_data = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `IRS_CTRL_ADDR: next_st.rd_data = {6'h00, st.ctrl};
                `IRS_STAT_ADDR: next_st.rd_data = {2'h0, st.seq_active, st.mask_bit_buffer, st.ibit,
                                                   st.pend.per, st.pend.ext, st.pend.nmi};
                `IRS_FLAG_ADDR: next_st.rd_data = {6'h00, st.capture_flag, st.strobe_flag};
                default:        next_st.rd_data = 8'h00;
            endcase
        end
    end

    // =====================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st                 <= '0;
            st.sync1           <= `IRS_LINES_IDLE;
            st.sync2           <= `IRS_LINES_IDLE;
            st.sync3           <= `IRS_LINES_IDLE;
            st.filt            <= `IRS_LINES_IDLE;
            st.samp            <= `IRS_LINES_IDLE;
            st.nmi_prev        <= 1'b1;
            st.strb_prev       <= 1'b1;
            st.ibit            <= 1'b1;
            st.mask_bit_buffer <= 1'b1;
            st.ctrl            <= `IRS_CTRL_RESET;
            st.strobe_req_n    <= 1'b1;
            st.periph_req_n    <= 1'b1;
            st.select          <= IRS_SRC_NONE;
        end else begin
            st <= next_st;
        end
    end

    // =====================================================
    // outputs
    assign rd_data_o                       = st.rd_data;
    assign pending_o                       = st.pend;
    assign service_select_o                = st.select;
    assign mask_bit_o                      = st.ibit;
    assign strobe_interrupt_request_n_o    = st.strobe_req_n;
    assign internal_peripheral_request_n_o = st.periph_req_n;
    assign e_fall_o                        = e_fall;

    // =====================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    nmi_edge_set_a: assert property (nmi_edge && !tenth |=> st.pend.nmi)
        else $error("non-maskable edge did not set its latch");
    nmi_rise_cause_a: assert property ($rose(st.pend.nmi) |-> $past(nmi_edge))
        else $error("non-maskable latch set without an edge");
    tenth_clear_a: assert property (tenth && !st.seq_swi |=> !st.pend.nmi)
        else $error("non-maskable latch survived tenth cycle");
    mask_holds_a: assert property (st.ibit |-> !st.pend.ext && !st.pend.per)
        else $error("maskable latch pending under mask");
    tenth_mask_a: assert property (tenth |=> st.ibit && st.mask_bit_buffer)
        else $error("sequence did not set mask");
    ext_priority_a: assert property (st.pend.ext && !st.pend.nmi |-> st.select == IRS_SRC_EXT)
        else $error("external request lost priority");
    clear_delay_a: assert property ($fell(st.ibit) |-> $past(e_fall) && !$past(st.mask_bit_buffer))
        else $error("mask cleared without buffer delay");
    set_now_a: assert property (mask_set_i |=> st.ibit)
        else $error("mask set was delayed");
    strobe_mode_a: assert property (!st.strobe_req_n |-> $past(mode_i == `IRS_MODE_A || mode_i == `IRS_MODE_B))
        else $error("strobe request outside modes 4 and 7");
    sample_edge_a: assert property ($rose(st.pend.per) |-> $past(e_fall))
        else $error("peripheral latch set off the enable edge");
    nmi_priority_a: assert property (st.pend.nmi |-> st.select == IRS_SRC_NMI)
        else $error("non-maskable request not ranked first");
    per_select_a: assert property (st.pend.per && !st.pend.ext && !st.pend.nmi |-> st.select == IRS_SRC_PER)
        else $error("peripheral request not selected");
    ext_set_a: assert property (e_fall && !st.samp.ext && !st.ibit && !mask_set_i && !tenth |=> st.pend.ext)
        else $error("sampled external request did not set its latch");
    strobe_on_a: assert property ((mode_i == `IRS_MODE_A || mode_i == `IRS_MODE_B) && st.strobe_flag
                                  && st.ctrl[`IRS_CTRL_STRB_EN] |=> !st.strobe_req_n)
        else $error("strobe request not raised");
    buffer_hold_a: assert property (st.ibit && st.mask_bit_buffer |=> st.ibit)
        else $error("mask cleared without buffer delay");
endmodule

// *** sim/interrupt_request_sampling_tb.sv ***
// self-checking bench for the interrupt request sampling block
`timescale 1ns/10ps
`include "irs_params.svh"
module interrupt_request_sampling_tb;
    import irs_pkg::*;
    logic            clk_i, rst_i, ser_en, software_interrupt_instr, wr_i, rd_i;
    logic [10:0]     pls;
    logic            nmi_n, ext_n, stb_n, ser_f, mask, strb_n, per_n, efall;
    logic [2:0]      mode;
    logic [1:0]      addr;
    logic [7:0]      wdata, rd_data;
    irs_pend_t       pend;
    irs_src_t        sel;
    wire logic [4:0] watch = {pend, mask, per_n};
    int              fails, total_checks;
    irs_far_side #(.HOLD(8)) far (
        .clk_i(clk_i), .rst_i(rst_i), .nmi_raise_i(pls[0]), .nmi_clear_i(pls[1]),
        .ext_raise_i(pls[2]), .ext_clear_i(pls[3]), .strobe_pulse_i(pls[4]),
        .serial_raise_i(pls[5]), .serial_clear_i(pls[6]), .nmi_n_o(nmi_n), .ext_n_o(ext_n),
        .strobe_n_o(stb_n), .serial_flag_o(ser_f));
    irs_request_sampling #(.E_DIV(2)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .nonmaskable_request_n_i(nmi_n),
        .external_maskable_request_n_i(ext_n), .port_strobe_input_n_i(stb_n), .mode_i(mode),
        .capture_event_i(pls[7]), .serial_flag_i(ser_f), .serial_enable_i(ser_en),
        .seq_start_i(pls[8]), .software_interrupt_instr_i(software_interrupt_instr), .mask_set_i(pls[9]),
        .mask_clear_i(pls[10]), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr_i), .rd_i(rd_i),
        .rd_data_o(rd_data), .pending_o(pend), .service_select_o(sel), .mask_bit_o(mask),
        .strobe_interrupt_request_n_o(strb_n), .internal_peripheral_request_n_o(per_n),
        .e_fall_o(efall));
    // =====================================================
    // helpers
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic pulse(input logic [10:0] m);
        @(posedge clk_i);
        pls <= m;
        @(posedge clk_i);
        pls <= 11'h000;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr_i  <= 1'b1;
        @(posedge clk_i);
        wr_i  <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_i);
        addr <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rd_data, exp, what);
        @(posedge clk_i);
        #1 chk(rd_data, 8'h00, "read data stands one cycle");
    endtask
    task automatic wait_bit(input int i, input logic v, input string what);
        int n;
        #1;
        for (n = 0; n < 200 && watch[i] !== v; n++) begin
            @(posedge clk_i);
            #1;
        end
        chk(8'(watch[i]), 8'(v), what);
        if (n == 200) begin
            test_done();
        end
    endtask
    // =====================================================
    // scenarios
    task automatic t_reset;
        #1 chk({pend, sel, mask, strb_n, per_n}, 8'h07, "reset outputs");
        rd(`IRS_CTRL_ADDR, 8'h00, "ctrl reset");
        rd(`IRS_STAT_ADDR, 8'h18, "status reset");
        $display("test reset done");
    endtask
    task automatic t_enable;
        int cnt;
        cnt = 0;
        repeat (20) begin
            @(posedge clk_i);
            #1 cnt += efall;
        end
        chk(8'(cnt), 8'h0A, "enable edge rate");
        $display("test enable done");
    endtask
    task automatic t_rerst;
        pulse(11'h001);
        wait_bit(4, 1'b1, "nmi before reset");
        @(posedge clk_i);
        rst_i <= 1'b1;
        cyc(2);
        rst_i <= 1'b0;
        cyc(1);
        #1 chk({pend, sel, mask}, 8'h01, "mid-run reset");
        cyc(10);
        #1 chk(pend.nmi, 1'b0, "no edge after reset");
        $display("test rerst done");
    endtask
    task automatic t_mask;
        pulse(11'h004);
        cyc(20);
        #1 chk(watch, 8'h03, "masked request");
        pulse(11'h400);
        #1 chk(mask, 1'b1, "mask clear delayed");
        wait_bit(1, 1'b0, "mask cleared");
        wait_bit(3, 1'b1, "ext pending");
        @(posedge clk_i);
        ser_en <= 1'b1;
        pulse(11'h020);
        wait_bit(0, 1'b0, "peripheral line");
        wait_bit(2, 1'b1, "per pending");
        cyc(2);
        #1 chk(sel, IRS_SRC_EXT, "ext over per");
        pulse(11'h200);
        #1 chk(watch, 8'h02, "mask set at once");
        @(posedge clk_i);
        ser_en <= 1'b0;
        cyc(3);
        #1 chk(per_n, 1'b1, "enable gates request");
        pulse(11'h040);
        $display("test mask done");
    endtask
    task automatic t_nmi;
        pulse(11'h400);
        wait_bit(1, 1'b0, "mask cleared");
        wait_bit(3, 1'b1, "ext pending");
        pulse(11'h001);
        wait_bit(4, 1'b1, "nmi pending");
        cyc(2);
        #1 chk(sel, IRS_SRC_NMI, "nmi ranks first");
        pulse(11'h100);
        wait_bit(4, 1'b0, "nmi cleared by sequence");
        chk(watch[3:1], 8'h01, "sequence sets mask");
        cyc(20);
        #1 chk(pend.nmi, 1'b0, "steady low ignored");
        pulse(11'h002);
        cyc(8);
        pulse(11'h001);
        wait_bit(4, 1'b1, "new edge");
        @(posedge clk_i);
        software_interrupt_instr <= 1'b1;
        pulse(11'h100);
        cyc(40);
        #1 chk(pend.nmi, 1'b1, "software sequence keeps nmi");
        @(posedge clk_i);
        software_interrupt_instr <= 1'b0;
        pulse(11'h100);
        wait_bit(4, 1'b0, "nmi cleared again");
        pulse(11'h00A);
        cyc(30);
        $display("test nmi done");
    endtask
    task automatic t_strobe;
        pulse(11'h010);
        cyc(12);
        rd(`IRS_FLAG_ADDR, 8'h01, "strobe flag");
        chk(strb_n, 1'b1, "strobe disabled");
        wr(`IRS_CTRL_ADDR, 8'h01);
        for (int m = 0; m < 8; m++) begin
            @(posedge clk_i);
            mode <= m[2:0];
            cyc(3);
            #1 chk(strb_n, (m == 4 || m == 7) ? 1'b0 : 1'b1, "strobe by mode");
        end
        wr(`IRS_FLAG_ADDR, 8'h01);
        cyc(2);
        #1 chk(strb_n, 1'b1, "strobe flag cleared");
        wr(`IRS_CTRL_ADDR, 8'h02);
        pulse(11'h080);
        cyc(2);
        #1 chk(per_n, 1'b0, "capture request");
        rd(`IRS_FLAG_ADDR, 8'h02, "capture flag");
        wr(`IRS_FLAG_ADDR, 8'h02);
        cyc(2);
        #1 chk(per_n, 1'b1, "capture cleared");
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h00, "unmapped read");
        rd(`IRS_CTRL_ADDR, 8'h02, "ctrl kept");
        $display("test strobe done");
    endtask
    // =====================================================
    // clock and main sequence
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        rst_i        = 1'b1;
        {ser_en, software_interrupt_instr, wr_i, rd_i} = 4'h0;
        pls          = 11'h000;
        mode         = 3'h0;
        addr         = 2'h0;
        wdata        = 8'h00;
        fails        = 0;
        total_checks = 0;
        cyc(10);
        rst_i <= 1'b0;
        cyc(1);
        t_reset();
        t_enable();
        t_mask();
        t_nmi();
        t_strobe();
        t_rerst();
        test_done();
    end
endmodule

// *** sim/irs_far_side.sv ***
// far side model: external requesters, strobe pin and serial status flag
`timescale 1ns/10ps
module irs_far_side #(
    parameter int HOLD = 8
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic nmi_raise_i,
    input  wire logic nmi_clear_i,
    input  wire logic ext_raise_i,
    input  wire logic ext_clear_i,
    input  wire logic strobe_pulse_i,
    input  wire logic serial_raise_i,
    input  wire logic serial_clear_i,
    output logic      nmi_n_o,
    output logic      ext_n_o,
    output logic      strobe_n_o,
    output logic      serial_flag_o
);
    logic [7:0] strobe_cnt;
    // =====================================================
    // requesters hold their line low until software clears them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_n_o       <= 1'b1;
            ext_n_o       <= 1'b1;
            serial_flag_o <= 1'b0;
            strobe_cnt    <= 8'h00;
        end else begin
            nmi_n_o       <= nmi_raise_i ? 1'b0 : (nmi_clear_i ? 1'b1 : nmi_n_o);
            ext_n_o       <= ext_raise_i ? 1'b0 : (ext_clear_i ? 1'b1 : ext_n_o);
            serial_flag_o <= serial_raise_i ? 1'b1 : (serial_clear_i ? 1'b0 : serial_flag_o);
            strobe_cnt    <= strobe_pulse_i ? 8'(HOLD) : (strobe_cnt != 8'h00 ? strobe_cnt - 8'h01 : 8'h00);
        end
    end
    // =====================================================
    // strobe pin low for longer than one enable cycle, pulled up otherwise
    assign strobe_n_o = (strobe_cnt == 8'h00);
endmodule
